// ===== common/cam_pkg.sv
`default_nettype none

package cam_pkg;

  // ==========================================================
  // instruction encodings (10-bit words)
  // ==========================================================
  localparam logic [9:0] CAM_OP_NOP      = 10'h000;
  localparam logic [9:0] CAM_OP_ADD_MEM  = 10'h00a;
  localparam logic [9:0] CAM_OP_ADD_MEMC = 10'h00b;
  localparam logic [9:0] CAM_OP_AND      = 10'h018;
  localparam logic [5:0] CAM_OP_IMM_HI   = 6'h06;
  localparam int         CAM_IMM_MSB     = 3;
  localparam int         CAM_OPHI_LSB    = 4;
  localparam logic [9:0] CAM_OP_CLK_MODE = 10'h002;
  localparam logic [9:0] CAM_OP_RAM_BKUP = 10'h008;
  localparam logic [9:0] CAM_OP_PD_EN    = 10'h05b;
  localparam logic [9:0] CAM_OP_WDT_STOP = 10'h29c;
  localparam logic [9:0] CAM_OP_WDT_RST  = 10'h2a0;
  localparam logic [9:0] CAM_OP_VDROP_EN = 10'h293;

  // ==========================================================
  // register map (byte offsets, low address bits only)
  // ==========================================================
  localparam int         CAM_ADDR_W      = 8;
  localparam logic [7:0] CAM_OFS_ACC     = 8'h00;
  localparam logic [7:0] CAM_OFS_CARRY   = 8'h04;
  localparam logic [7:0] CAM_OFS_DPTR    = 8'h08;
  localparam logic [7:0] CAM_OFS_STATE   = 8'h0c;
  localparam logic [7:0] CAM_OFS_IRQ_ST  = 8'h10;
  localparam logic [7:0] CAM_OFS_IRQ_MSK = 8'h14;

  // state register fields
  localparam int CAM_ST_CLK_MODE  = 0;
  localparam int CAM_ST_RAM_BKUP  = 1;
  localparam int CAM_ST_PD_EN     = 2;
  localparam int CAM_ST_WDT_STOP  = 3;
  localparam int CAM_ST_VDROP     = 4;
  localparam int CAM_ST_WATCHDOG_FLAG_ONE      = 5;
  localparam int CAM_ST_SKIP      = 6;
  localparam int CAM_ST_W         = 7;

  // interrupt fields
  localparam int CAM_IRQ_CLK_MODE = 0;
  localparam int CAM_IRQ_RAM_BKUP = 1;
  localparam int CAM_IRQ_WATCHDOG_FLAG_ONE     = 2;
  localparam int CAM_IRQ_W        = 3;

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [3:0]  CAM_RST_ACC   = 4'h0;
  localparam logic        CAM_RST_CARRY = 1'b0;
  localparam logic [2:0]  CAM_RST_MASK  = 3'h0;
  localparam logic [31:0] CAM_RST_RDATA = 32'h0000_0000;

  // ==========================================================
  // types
  // ==========================================================
  typedef enum logic [1:0] {
    CAM_MODE_RUN    = 2'b00,
    CAM_MODE_CLOCK  = 2'b01,
    CAM_MODE_BACKUP = 2'b10
  } cam_mode_t;

  typedef enum logic [1:0] {
    CAM_ALU_ADD_IMM = 2'b00,
    CAM_ALU_ADD_MEM = 2'b01,
    CAM_ALU_ADD_CY  = 2'b11,
    CAM_ALU_AND     = 2'b10
  } cam_alu_op_t;

endpackage : cam_pkg

`default_nettype wire

// ===== common/cam_alu_if.sv
`default_nettype none

interface cam_alu_if;
  import cam_pkg::*;
  cam_alu_op_t op;
  logic [3:0]  a;
  logic [3:0]  b;
  logic        cin;
  logic [3:0]  res;
  logic        cout;

  modport core (output op, output a, output b, output cin,
                input res, input cout);
  modport alu  (input op, input a, input b, input cin,
                output res, output cout);
endinterface : cam_alu_if

`default_nettype wire

// ===== verilog/cam_alu.sv
`default_nettype none

module cam_alu
  import cam_pkg::*;
(
  cam_alu_if.alu bus
);

  logic [4:0] sum;

  // ==========================================================
  // nibble arithmetic
  // ==========================================================
  always_comb begin
    sum = 5'h00;
    case (bus.op)
      CAM_ALU_ADD_IMM,
      CAM_ALU_ADD_MEM: begin
        sum = {1'b0, bus.a} + {1'b0, bus.b};
      end
      CAM_ALU_ADD_CY: begin
        sum = {1'b0, bus.a} + {1'b0, bus.b} + {4'h0, bus.cin};
      end
      CAM_ALU_AND: begin
        sum = {1'b0, bus.a & bus.b};
      end
      default: begin
        sum = 5'h00;
      end
    endcase
  end

  assign bus.res  = sum[3:0];
  assign bus.cout = sum[4];

endmodule : cam_alu

`default_nettype wire

// ===== verilog/cam_core.sv
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`default_nettype none

module cam_core
  import cam_pkg::*;
#(
  parameter int unsigned DPTR_W    = 9,
  parameter bit          H_VERSION = 1'b1
)(
  input  wire  logic              hclk,
  input  wire  logic              hresetn,
  input  wire  logic              hsel,
  input  wire  logic [31:0]       haddr,
  input  wire  logic [1:0]        htrans,
  input  wire  logic              hwrite,
  input  wire  logic [2:0]        hsize,
  input  wire  logic [31:0]       hwdata,
  input  wire  logic              hready,
  output var   logic              hreadyout,
  output var   logic              hresp,
  output var   logic [31:0]       hrdata,
  input  wire  logic              instr_valid,
  input  wire  logic [9:0]        instr_word,
  output var   logic              instr_ready,
  input  wire  logic [3:0]        mem_rdata,
  output var   logic [DPTR_W-1:0] data_pointer,
  input  wire  logic              wdt_flag_set,
  input  wire  logic              wakeup,
  output var   logic              clock_mode,
  output var   logic              ram_backup,
  output var   logic              wdt_stop_en,
  output var   logic              vdrop_en,
  output var   logic              skip_active,
  output var   logic              irq
);

  // ==========================================================
  // parameter checks
  // ==========================================================
  if (DPTR_W < 1 || DPTR_W > 16) begin : g_bad_dptr
    $error("cam_core: DPTR_W must be 1 to 16");
  end

  // ==========================================================
  // functions
  // ==========================================================
  // hardware set wins over a software clear in the same cycle
  function automatic logic [CAM_IRQ_W-1:0] sticky(
    input logic [CAM_IRQ_W-1:0] cur,
    input logic [CAM_IRQ_W-1:0] set,
    input logic [CAM_IRQ_W-1:0] clr
  );
    return set | (cur & ~clr);
  endfunction : sticky

  function automatic logic op_is(
    input logic [9:0] w,
    input logic [9:0] code
  );
    return w == code;
  endfunction : op_is

  // ==========================================================
  // state
  // ==========================================================
  cam_mode_t             mode_r;
  cam_mode_t             mode_nxt;
  logic [3:0]            acc_r;
  logic [3:0]            acc_nxt;
  logic                  carry_flag_r;
  logic                  carry_flag_nxt;
  logic [DPTR_W-1:0]     dptr_r;
  logic [DPTR_W-1:0]     dptr_nxt;
  logic                  skip_r;
  logic                  skip_nxt;
  logic                  pd_en_r;
  logic                  pd_en_nxt;
  logic                  wdt_stop_r;
  logic                  wdt_stop_nxt;
  logic                  vdrop_r;
  logic                  vdrop_nxt;
  logic                  watchdog_flag_one_r;
  logic                  watchdog_flag_one_nxt;
  logic [CAM_IRQ_W-1:0]  irq_st_r;
  logic [CAM_IRQ_W-1:0]  irq_st_nxt;
  logic [CAM_IRQ_W-1:0]  irq_msk_r;
  logic [CAM_IRQ_W-1:0]  irq_msk_nxt;
  logic                  instr_ready_r;
  logic                  irq_r;

  // bus slave state
  logic                  wr_pend_r;
  logic                  rd_pend_r;
  logic [CAM_ADDR_W-1:0] addr_q_r;
  logic                  hreadyout_r;
  logic [31:0]           hrdata_r;
  logic                  hresp_r;

  cam_alu_if alu_bus ();

  cam_alu u_alu (
    .bus (alu_bus)
  );

  // ==========================================================
  // bus decode
  // ==========================================================
  // hsize is accepted but every access is treated as a word
  wire logic addr_phase = hsel & htrans[1] & hready;
  wire logic bus_wr_acc = wr_pend_r & (addr_q_r == CAM_OFS_ACC);
  wire logic bus_wr_cy  = wr_pend_r & (addr_q_r == CAM_OFS_CARRY);
  wire logic bus_wr_dp  = wr_pend_r & (addr_q_r == CAM_OFS_DPTR);
  wire logic bus_wr_st  = wr_pend_r & (addr_q_r == CAM_OFS_STATE);
  wire logic bus_wr_ist = wr_pend_r & (addr_q_r == CAM_OFS_IRQ_ST);
  wire logic bus_wr_msk = wr_pend_r & (addr_q_r == CAM_OFS_IRQ_MSK);

  wire logic [CAM_ST_W-1:0] state_word = {
    skip_r,
    watchdog_flag_one_r,
    vdrop_r,
    wdt_stop_r,
    pd_en_r,
    mode_r == CAM_MODE_BACKUP,
    mode_r == CAM_MODE_CLOCK
  };

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (addr_q_r)
      CAM_OFS_ACC: begin
        rd_mux = {28'h000_0000, acc_r};
      end
      CAM_OFS_CARRY: begin
        rd_mux = {31'h0000_0000, carry_flag_r};
      end
      CAM_OFS_DPTR: begin
        rd_mux = 32'(dptr_r);
      end
      CAM_OFS_STATE: begin
        rd_mux = 32'(state_word);
      end
      CAM_OFS_IRQ_ST: begin
        rd_mux = 32'(irq_st_r);
      end
      CAM_OFS_IRQ_MSK: begin
        rd_mux = 32'(irq_msk_r);
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // ==========================================================
  // instruction decode
  // ==========================================================
  wire logic exec = instr_valid & instr_ready_r;
  wire logic run  = exec & ~skip_r;

  wire logic op_imm  = run &
    (instr_word[9:CAM_OPHI_LSB] == CAM_OP_IMM_HI);
  wire logic op_am   = run & op_is(instr_word, CAM_OP_ADD_MEM);
  wire logic op_amc  = run & op_is(instr_word, CAM_OP_ADD_MEMC);
  wire logic op_and  = run & op_is(instr_word, CAM_OP_AND);
  wire logic op_pof  = run & op_is(instr_word, CAM_OP_CLK_MODE);
  wire logic op_ram_backup_entry_op = run & op_is(instr_word, CAM_OP_RAM_BKUP);
  wire logic op_powerdown_enable_op = run & op_is(instr_word, CAM_OP_PD_EN);
  wire logic op_watchdog_stop_enable_op = run & op_is(instr_word, CAM_OP_WDT_STOP);
  wire logic op_watchdog_restart_op = run & op_is(instr_word, CAM_OP_WDT_RST);
  wire logic op_vdrop_detect_enable_op = run & op_is(instr_word, CAM_OP_VDROP_EN);

  wire logic arith   = op_imm | op_am | op_amc | op_and;

  // ==========================================================
  // arithmetic
  // ==========================================================
  assign alu_bus.op  = op_imm ? CAM_ALU_ADD_IMM :
                       op_amc ? CAM_ALU_ADD_CY  :
                       op_and ? CAM_ALU_AND     : CAM_ALU_ADD_MEM;
  assign alu_bus.a   = acc_r;
  assign alu_bus.b   = op_imm ? instr_word[CAM_IMM_MSB:0] : mem_rdata;
  assign alu_bus.cin = carry_flag_r;

  assign acc_nxt = arith      ? alu_bus.res :
                   bus_wr_acc ? hwdata[3:0] : acc_r;

  assign carry_flag_nxt = op_amc    ? alu_bus.cout :
                          bus_wr_cy ? hwdata[0]    : carry_flag_r;

  assign dptr_nxt = bus_wr_dp ? hwdata[DPTR_W-1:0] : dptr_r;

  // ==========================================================
  // skip control
  // ==========================================================
  // skip when an immediate add has no overflow, or a restart finds the watchdog flag set
  assign skip_nxt = exec ? ((op_imm & ~alu_bus.cout) |
                            (op_watchdog_restart_op & watchdog_flag_one_r))
                         : skip_r;

  // ==========================================================
  // power-down control
  // ==========================================================
  // enable only reaches the next executed word
  assign pd_en_nxt = op_powerdown_enable_op ? 1'b1 : (run ? 1'b0 : pd_en_r);

  wire logic pd_clk = op_pof  & pd_en_r;
  wire logic pd_bku = op_ram_backup_entry_op & pd_en_r;
  wire logic wake   = wakeup | (bus_wr_st & hwdata[CAM_ST_CLK_MODE]);

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      CAM_MODE_RUN: begin
        if (pd_clk) begin
          mode_nxt = CAM_MODE_CLOCK;
        end else if (pd_bku) begin
          mode_nxt = CAM_MODE_BACKUP;
        end
      end
      CAM_MODE_CLOCK,
      CAM_MODE_BACKUP: begin
        if (wake) begin
          mode_nxt = CAM_MODE_RUN;
        end
      end
      default: begin
        mode_nxt = CAM_MODE_RUN;
      end
    endcase
  end

  // ==========================================================
  // watchdog and detector enables
  // ==========================================================
  // stop enable only, flag untouched
  assign wdt_stop_nxt = wdt_stop_r | op_watchdog_stop_enable_op;

  // restart clears flag, timer set wins
  assign watchdog_flag_one_nxt = wdt_flag_set |
                                 (watchdog_flag_one_r & ~op_watchdog_restart_op);

  assign vdrop_nxt = vdrop_r | (op_vdrop_detect_enable_op & H_VERSION);

  // ==========================================================
  // interrupts
  // ==========================================================
  wire logic [CAM_IRQ_W-1:0] irq_ev = {wdt_flag_set, pd_bku, pd_clk};
  wire logic [CAM_IRQ_W-1:0] irq_clr =
    bus_wr_ist ? hwdata[CAM_IRQ_W-1:0] : '0;

  assign irq_st_nxt  = sticky(irq_st_r, irq_ev, irq_clr);
  assign irq_msk_nxt = bus_wr_msk ? hwdata[CAM_IRQ_W-1:0] : irq_msk_r;

  // ==========================================================
  // registers
  // ==========================================================
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r              <= CAM_MODE_RUN;
      acc_r               <= CAM_RST_ACC;
      carry_flag_r        <= CAM_RST_CARRY;
      dptr_r              <= '0;
      skip_r              <= 1'b0;
      pd_en_r             <= 1'b0;
      wdt_stop_r          <= 1'b0;
      vdrop_r             <= 1'b0;
      watchdog_flag_one_r <= 1'b0;
    end else begin
      mode_r              <= mode_nxt;
      acc_r               <= acc_nxt;
      carry_flag_r        <= carry_flag_nxt;
      dptr_r              <= dptr_nxt;
      skip_r              <= skip_nxt;
      pd_en_r             <= pd_en_nxt;
      wdt_stop_r          <= wdt_stop_nxt;
      vdrop_r             <= vdrop_nxt;
      watchdog_flag_one_r <= watchdog_flag_one_nxt;
    end
  end

  // cpu halts from the cycle after a mode entry until wake, no word is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st_r      <= '0;
      irq_msk_r     <= CAM_RST_MASK;
      instr_ready_r <= 1'b0;
      irq_r         <= 1'b0;
    end else begin
      irq_st_r      <= irq_st_nxt;
      irq_msk_r     <= irq_msk_nxt;
      instr_ready_r <= (mode_nxt == CAM_MODE_RUN);
      irq_r         <= |(irq_st_nxt & irq_msk_nxt);
    end
  end

  // ==========================================================
  // bus slave
  // ==========================================================
  // reads take one wait state so the word reflects this cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r   <= 1'b0;
      rd_pend_r   <= 1'b0;
      addr_q_r    <= '0;
      hreadyout_r <= 1'b1;
      hrdata_r    <= CAM_RST_RDATA;
      hresp_r     <= 1'b0;
    end else begin
      wr_pend_r   <= addr_phase & hwrite;
      rd_pend_r   <= addr_phase & ~hwrite;
      hreadyout_r <= ~(addr_phase & ~hwrite);
      hresp_r     <= 1'b0;
      if (addr_phase) begin
        addr_q_r <= haddr[CAM_ADDR_W-1:0];
      end
      if (rd_pend_r) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign hreadyout    = hreadyout_r;
  assign hresp        = hresp_r;
  assign hrdata       = hrdata_r;
  assign instr_ready  = instr_ready_r;
  assign data_pointer = dptr_r;
  // one-hot mode bits, so both come straight from the mode flop
  assign clock_mode   = mode_r[0];
  assign ram_backup   = mode_r[1];
  assign wdt_stop_en  = wdt_stop_r;
  assign vdrop_en     = vdrop_r;
  assign skip_active  = skip_r;
  assign irq          = irq_r;

endmodule : cam_core

`default_nettype wire

// ===== verification/cam_core_sva.sv
`default_nettype none

module cam_core_sva
  import cam_pkg::*;
#(
  parameter bit H_VERSION = 1'b1
)(
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       instr_valid,
  input wire logic [9:0] instr_word,
  input wire logic       instr_ready,
  input wire logic       clock_mode,
  input wire logic       ram_backup,
  input wire logic       wdt_stop_en,
  input wire logic       vdrop_en,
  input wire logic       skip_active
);
  // ==========================================================
  // executed word and arming tracker
  // ==========================================================
  wire logic ex;
  logic      armed_r;
  assign ex = instr_valid && instr_ready && !skip_active;

  // idle cycles keep the arming, any other executed word drops it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_r <= 1'b0;
    end else if (ex) begin
      armed_r <= (instr_word == CAM_OP_PD_EN);
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ==========================================================
  // properties
  // ==========================================================
  property p_nop;
    ex && instr_word == CAM_OP_NOP |=> !skip_active
      && $stable(clock_mode) && $stable(wdt_stop_en) && $stable(vdrop_en);
  endproperty
  a_nop: assert property (p_nop)
    else $error("nop changed state");

  property p_and;
    ex && instr_word == CAM_OP_AND |=> !skip_active;
  endproperty
  a_and: assert property (p_and)
    else $error("and raised skip");

  property p_clk;
    ex && instr_word == CAM_OP_CLK_MODE && armed_r |=> clock_mode;
  endproperty
  a_clk: assert property (p_clk)
    else $error("clock mode not entered");

  property p_bkup;
    ex && instr_word == CAM_OP_RAM_BKUP && armed_r |=> ram_backup;
  endproperty
  a_bkup: assert property (p_bkup)
    else $error("backup mode not entered");

  property p_noarm;
    ex && !armed_r && (instr_word == CAM_OP_CLK_MODE
      || instr_word == CAM_OP_RAM_BKUP) |=> !clock_mode && !ram_backup;
  endproperty
  a_noarm: assert property (p_noarm)
    else $error("mode entered without enable");

  property p_wdt;
    ex && instr_word == CAM_OP_WDT_STOP |=> wdt_stop_en;
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("watchdog stop enable not set");

  property p_vdrop;
    ex && instr_word == CAM_OP_VDROP_EN |=> vdrop_en == H_VERSION;
  endproperty
  a_vdrop: assert property (p_vdrop)
    else $error("vdrop enable wrong");

  property p_skip;
    instr_valid && instr_ready && skip_active |=> !skip_active
      && $stable(wdt_stop_en) && $stable(vdrop_en) && !clock_mode;
  endproperty
  a_skip: assert property (p_skip)
    else $error("skipped word had effect");

  property p_halt;
    (clock_mode || ram_backup) [*2] |-> !instr_ready;
  endproperty
  a_halt: assert property (p_halt)
    else $error("words taken while halted");

endmodule : cam_core_sva

bind cam_core cam_core_sva #(.H_VERSION(H_VERSION)) u_cam_core_sva (
  .hclk        (hclk),
  .hresetn     (hresetn),
  .instr_valid (instr_valid),
  .instr_word  (instr_word),
  .instr_ready (instr_ready),
  .clock_mode  (clock_mode),
  .ram_backup  (ram_backup),
  .wdt_stop_en (wdt_stop_en),
  .vdrop_en    (vdrop_en),
  .skip_active (skip_active)
);

`default_nettype wire

// ===== verification/cam_core_tb_top.sv
`default_nettype none

module cam_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cam_pkg::*;

  typedef struct packed {
    logic [9:0] w;
    logic [3:0] a;
    logic [3:0] m;
    logic       c;
    logic [3:0] ea;
    logic       ec;
    logic       es;
  } cam_row_t;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        instr_valid;
  logic [9:0]  instr_word;
  logic        instr_ready;
  logic [3:0]  mem_rdata;
  logic [8:0]  data_pointer;
  logic        wdt_flag_set;
  logic        wakeup;
  logic        clock_mode;
  logic        ram_backup;
  logic        wdt_stop_en;
  logic        vdrop_en;
  logic        skip_active;
  logic        irq;
  logic [31:0] rd;
  int          miscompares;
  int          n_checks;
  cam_row_t    rows [9];
  logic [7:0]  offs [7];

  cam_core #(.DPTR_W(9), .H_VERSION(1'b1)) u_cam_core (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .mem_rdata(mem_rdata),
    .data_pointer(data_pointer), .wdt_flag_set(wdt_flag_set),
    .wakeup(wakeup), .clock_mode(clock_mode), .ram_backup(ram_backup),
    .wdt_stop_en(wdt_stop_en), .vdrop_en(vdrop_en),
    .skip_active(skip_active), .irq(irq)
  );

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // ==========================================================
  // helpers
  // ==========================================================
  task automatic finish_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask : chk

  // samples before this edge's updates land
  task automatic wait_hi(input bit ir);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while ((ir ? instr_ready : hreadyout) !== 1'b1 && n < 50);
    if ((ir ? instr_ready : hreadyout) !== 1'b1) begin
      miscompares++;
      finish_test();
    end
  endtask : wait_hi

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_hi(1'b0);
    htrans <= 2'b00;
    hwdata <= d;
    wait_hi(1'b0);
    rd = hrdata;
    hwdata <= ~d;
    chk("hresp", {31'h0, hresp}, 32'h0);
    // let the write land before callers look at outputs
    #1;
  endtask : ahb

  task automatic run(input logic [9:0] w, input logic [3:0] m);
    @(posedge hclk);
    instr_valid <= 1'b1;
    instr_word <= w;
    mem_rdata <= m;
    wait_hi(1'b1);
    instr_valid <= 1'b0;
    mem_rdata <= ~m;
    #1;
  endtask : run

  task automatic pulse(input bit wd);
    @(posedge hclk);
    if (wd) begin
      wdt_flag_set <= 1'b1;
    end else begin
      wakeup <= 1'b1;
    end
    @(posedge hclk);
    wdt_flag_set <= 1'b0;
    wakeup <= 1'b0;
  endtask : pulse

  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
    {instr_valid, instr_word, mem_rdata, wdt_flag_set, wakeup} = '0;
    hsize = 3'h2;
    miscompares = 0;
    n_checks = 0;
    rows = '{
      '{{CAM_OP_IMM_HI, 4'h5}, 4'h3, 4'h0, 1'b1, 4'h8, 1'b1, 1'b1},
      '{{CAM_OP_IMM_HI, 4'hf}, 4'hc, 4'h0, 1'b0, 4'hb, 1'b0, 1'b0},
      '{{CAM_OP_IMM_HI, 4'h0}, 4'hf, 4'h0, 1'b0, 4'hf, 1'b0, 1'b1},
      '{CAM_OP_ADD_MEM, 4'h9, 4'h8, 1'b0, 4'h1, 1'b0, 1'b0},
      '{CAM_OP_ADD_MEMC, 4'h9, 4'h6, 1'b1, 4'h0, 1'b1, 1'b0},
      '{CAM_OP_ADD_MEMC, 4'h2, 4'h3, 1'b1, 4'h6, 1'b0, 1'b0},
      '{CAM_OP_ADD_MEMC, 4'hf, 4'h1, 1'b0, 4'h0, 1'b1, 1'b0},
      '{CAM_OP_AND, 4'hc, 4'ha, 1'b1, 4'h8, 1'b1, 1'b0},
      '{CAM_OP_NOP, 4'h5, 4'h0, 1'b0, 4'h5, 1'b0, 1'b0}};
    offs = '{CAM_OFS_ACC, CAM_OFS_CARRY, CAM_OFS_DPTR, CAM_OFS_STATE,
             CAM_OFS_IRQ_ST, CAM_OFS_IRQ_MSK, 8'h1c};
    repeat (2) @(posedge hclk);
    #1;
    chk("outs", {clock_mode, ram_backup, wdt_stop_en, vdrop_en,
        skip_active, irq, instr_ready}, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b1, 8'h1c, 32'hffff_ffff);
    foreach (offs[k]) begin
      ahb(1'b0, offs[k], 32'h0);
      chk("reg", rd, 32'h0);
    end
    ahb(1'b1, CAM_OFS_DPTR, 32'h1a5);
    chk("dptr", {23'h0, data_pointer}, 32'h1a5);
    foreach (rows[i]) begin
      ahb(1'b1, CAM_OFS_ACC, {28'h0, rows[i].a});
      ahb(1'b1, CAM_OFS_CARRY, {31'h0, rows[i].c});
      run(rows[i].w, rows[i].m);
      chk("skip", {31'h0, skip_active}, {31'h0, rows[i].es});
      if (skip_active === 1'b1)
        run(CAM_OP_NOP, 4'h0);
      ahb(1'b0, CAM_OFS_ACC, 32'h0);
      chk("acc", rd, {28'h0, rows[i].ea});
      ahb(1'b0, CAM_OFS_CARRY, 32'h0);
      chk("carry", rd, {31'h0, rows[i].ec});
    end
    // skipped add must leave the accumulator alone
    ahb(1'b1, CAM_OFS_ACC, 32'h1);
    run({CAM_OP_IMM_HI, 4'h2}, 4'h0);
    run({CAM_OP_IMM_HI, 4'hf}, 4'h0);
    chk("skip", {31'h0, skip_active}, 32'h0);
    ahb(1'b0, CAM_OFS_ACC, 32'h0);
    chk("acc", rd, 32'h3);
    run(CAM_OP_CLK_MODE, 4'h0);
    chk("clk", {31'h0, clock_mode}, 32'h0);
    run(CAM_OP_PD_EN, 4'h0);
    run(CAM_OP_NOP, 4'h0);
    run(CAM_OP_RAM_BKUP, 4'h0);
    chk("bkup", {31'h0, ram_backup}, 32'h0);
    ahb(1'b1, CAM_OFS_IRQ_MSK, 32'h1);
    run(CAM_OP_PD_EN, 4'h0);
    run(CAM_OP_CLK_MODE, 4'h0);
    chk("clk", {31'h0, clock_mode}, 32'h1);
    ahb(1'b0, CAM_OFS_IRQ_ST, 32'h0);
    chk("irqst", rd, 32'h1);
    chk("irq", {30'h0, irq, instr_ready}, 32'h2);
    ahb(1'b1, CAM_OFS_IRQ_ST, 32'h1);
    ahb(1'b0, CAM_OFS_IRQ_ST, 32'h0);
    chk("irq", {irq, rd[30:0]}, 32'h0);
    pulse(1'b0);
    ahb(1'b0, CAM_OFS_STATE, 32'h0);
    chk("wake", {rd[30:0], clock_mode}, 32'h0);
    run(CAM_OP_PD_EN, 4'h0);
    run(CAM_OP_RAM_BKUP, 4'h0);
    chk("bkup", {31'h0, ram_backup}, 32'h1);
    ahb(1'b0, CAM_OFS_IRQ_ST, 32'h0);
    chk("masked", {rd[30:0], irq}, 32'h4);
    ahb(1'b1, CAM_OFS_STATE, 32'h1);
    ahb(1'b0, CAM_OFS_STATE, 32'h0);
    chk("wake", {rd[30:0] & 31'h3, ram_backup}, 32'h0);
    pulse(1'b1);
    run(CAM_OP_WDT_STOP, 4'h0);
    ahb(1'b0, CAM_OFS_STATE, 32'h0);
    chk("wdt", rd & 32'h28, 32'h28);
    chk("stop", {31'h0, wdt_stop_en}, 32'h1);
    run(CAM_OP_WDT_RST, 4'h0);
    chk("wskip", {31'h0, skip_active}, 32'h1);
    ahb(1'b0, CAM_OFS_STATE, 32'h0);
    chk("wdf", rd & 32'h20, 32'h0);
    run(CAM_OP_NOP, 4'h0);
    run(CAM_OP_WDT_RST, 4'h0);
    chk("wskip", {31'h0, skip_active}, 32'h0);
    run(CAM_OP_VDROP_EN, 4'h0);
    chk("vdrop", {31'h0, vdrop_en}, 32'h1);
    // mid-run reset must drop the sticky enables
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    #1;
    chk("rst", {clock_mode, ram_backup, wdt_stop_en, vdrop_en,
        skip_active, irq, instr_ready}, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    chk("ready", {31'h0, instr_ready}, 32'h1);
    finish_test();
  end

endmodule : cam_core_tb_top

`default_nettype wire
